// ---- core/ddps_pkg.sv ----
// Package: constants shared by the debug port select block
package ddps_pkg;
  localparam int           SWITCH_CODE_W  = 16;
  localparam logic [15:0]  CODE_TO_TWO    = 16'h79e7;
  localparam logic [15:0]  CODE_TO_SCAN   = 16'h3ce7;
  localparam int           FRAME_HIGH_MIN = 50;
  localparam int           FRAME_CNT_W    = 7;
  localparam logic         PORT_SCAN_RST  = 1'b0;

  typedef enum logic [1:0] {
    DET_IDLE = 2'b00,
    DET_LEAD = 2'b01,
    DET_CODE = 2'b10,
    DET_TAIL = 2'b11
  } ddps_det_type;
endpackage

// ---- core/ddps_edge_sync.sv ----
// Two-flop synchroniser with rising edge detect
`timescale 1ns/1ns
module ddps_edge_sync (
  input  wire logic ref_clk,
  input  wire logic rst_b,
  input  wire logic asyncIn,
  output logic      syncOut,
  output logic      riseOut
);
  logic meta_ff;
  logic sync_ff;
  logic last_ff;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      last_ff <= 1'b0;
    end else begin
      meta_ff <= asyncIn;
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
    end
  end

  assign syncOut = sync_ff;
  assign riseOut = sync_ff & ~last_ff;
endmodule

// ---- core/ddps_cross_trigger.sv ----
// Cross-trigger unit: each core can halt and later release the other
`timescale 1ns/1ns
module ddps_cross_trigger (
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  input  wire logic [1:0] coreHalted,
  input  wire logic [1:0] haltRequest,
  input  wire logic [1:0] ctEnable,
  output logic [1:0]      ctHaltOut
);
  logic [1:0] halted_ff;
  logic [1:0] owner_ff;
  logic [1:0] nxt_owner;
  logic [1:0] enterDbg;
  logic [1:0] leaveDbg;

  assign enterDbg = coreHalted & ~halted_ff;
  assign leaveDbg = ~coreHalted & halted_ff;

  // owner_ff[i]: core i caused the halt now held on the other core
  always_comb begin
    nxt_owner = owner_ff;
    for (int i = 0; i < 2; i++) begin
      if (leaveDbg[i]) nxt_owner[i] = 1'b0;
      if (ctEnable[i] && (enterDbg[i] || haltRequest[i]))
        nxt_owner[i] = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      halted_ff   <= 2'b00;
      owner_ff    <= 2'b00;
      ctHaltOut   <= 2'b00;
    end else begin
      halted_ff <= coreHalted;
      owner_ff  <= nxt_owner;
      ctHaltOut <= {nxt_owner[0], nxt_owner[1]};
    end
  end
endmodule

// ---- core/ddps_port_select.sv ----
// Debug/test entry logic: mode straps, protocol switch, trace and triggers
// Functional notes
// - Test-select pin sampled at power-up: low normal, high test mode.
// - After reset the scan protocol is active, two-wire disabled.
// - Switch code framed by more than 50 high clocks each side.
// - Code 0x79e7, MSB first, switches scan to two-wire.
// - Code 0x3ce7, MSB first, switches two-wire back to scan.
// - On the two-wire code, scan logic off, two-wire logic on.
// - Async trace drives shared data-out pin only in two-wire mode.
// - Debug port works only with port-kind low; high is boundary scan.
// - Either core can halt the other into debug mode.
// - Halt sent when sender enters debug or on request.
// - Sender leaving debug also releases the other core.
// - Cross-trigger enables come from a software config register.
// - Debug port reaches memory whether core runs, halts or resets.
// - A 2-to-1 mux picks which core's trace reaches the pin.
// - One debug port feeds a separate bus access port per core.
`timescale 1ns/1ns
module ddps_port_select (
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  // Straps
  input  wire logic       testSelectPin,
  input  wire logic       portKindSelect,
  output logic            testModeOut,
  output logic            boundaryScanOut,
  // Shared debug pins
  input  wire logic       debugClockLine,
  input  wire logic       modeDataLineIn,
  input  wire logic       scanDataOut,
  input  wire logic       scanDataOutEn,
  output logic            dataOutTracePinOut,
  output logic            dataOutTracePinOe,
  // Port status
  output logic            scanPortEnable,
  output logic            twoWirePortEnable,
  // Trace sources
  input  wire logic [1:0] asyncTraceOut,
  input  wire logic       traceCoreSel,
  // Per-core bus access ports
  input  wire logic       dpAccessReq,
  input  wire logic       dpCoreSel,
  output logic [1:0]      busAccessReq,
  // Cross trigger
  input  wire logic [1:0] coreHalted,
  input  wire logic [1:0] haltRequest,
  input  wire logic [1:0] ctEnableCfg,
  output logic [1:0]      ctHaltOut
);

  ////////////////////////////////////////////////////////////////////
  // Straps caught after reset release

  logic strapDone_ff;
  logic testMode_ff;
  logic bscan_ff;
  logic tstSync;
  logic kindSync;

  ddps_edge_sync uTstSync (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .asyncIn (testSelectPin),
    .syncOut (tstSync),
    .riseOut ()
  );

  ddps_edge_sync uKindSync (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .asyncIn (portKindSelect),
    .syncOut (kindSync),
    .riseOut ()
  );

  // Later pin moves are ignored; a chip reset is needed to change mode
  // Both sync stages must fill before the strap levels are trusted
  logic strapWait_ff;
  logic strapSettle_ff;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      strapWait_ff <= 1'b0;
      strapSettle_ff <= 1'b0;
      strapDone_ff <= 1'b0;
      testMode_ff  <= 1'b0;
      bscan_ff     <= ddps_pkg::PORT_SCAN_RST;
    end else begin
      strapWait_ff <= 1'b1;
      strapSettle_ff <= strapWait_ff;
      if (strapSettle_ff && !strapDone_ff) begin
        strapDone_ff <= 1'b1;
        testMode_ff  <= tstSync;
        bscan_ff     <= kindSync;
      end
    end
  end

  assign testModeOut     = testMode_ff;
  assign boundaryScanOut = bscan_ff;

  ////////////////////////////////////////////////////////////////////
  // Switch-sequence detector on the debug clock

  logic clkRise;
  logic mdSync;

  ddps_edge_sync uClkSync (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .asyncIn (debugClockLine),
    .syncOut (),
    .riseOut (clkRise)
  );

  ddps_edge_sync uMdSync (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .asyncIn (modeDataLineIn),
    .syncOut (mdSync),
    .riseOut ()
  );

  localparam logic [ddps_pkg::FRAME_CNT_W-1:0] HIGH_NEED =
    ddps_pkg::FRAME_CNT_W'(ddps_pkg::FRAME_HIGH_MIN + 1);
  localparam logic [ddps_pkg::FRAME_CNT_W-1:0] CNT_MAX = '1;
  localparam logic [4:0] CODE_LAST =
    5'(ddps_pkg::SWITCH_CODE_W - 1);
  // The tail test runs on the rise whose high is still being counted
  localparam logic [ddps_pkg::FRAME_CNT_W-1:0] TAIL_NEED =
    HIGH_NEED - 1'b1;

  // Comparison shared by both switch codes
  function automatic logic code_is(
    input logic [15:0] got,
    input logic [15:0] want
  );
    return got == want;
  endfunction

  // Frame length test shared by the lead-in and the trailing frame
  function automatic logic frame_met(
    input logic [ddps_pkg::FRAME_CNT_W-1:0] cnt,
    input logic [ddps_pkg::FRAME_CNT_W-1:0] need
  );
    return cnt >= need;
  endfunction

  ddps_pkg::ddps_det_type state_ff;
  ddps_pkg::ddps_det_type nxt_state;
  logic [ddps_pkg::FRAME_CNT_W-1:0] highCnt_ff;
  logic [ddps_pkg::FRAME_CNT_W-1:0] nxt_highCnt;
  logic [15:0] shift_ff;
  logic [15:0] nxt_shift;
  logic [4:0]  bitCnt_ff;
  logic [4:0]  nxt_bitCnt;
  logic        twoWire_ff;
  logic        nxt_twoWire;
  logic        pendTwo_ff;
  logic        nxt_pendTwo;
  logic [15:0] shiftIn;
  logic        codeTwo;
  logic        codeScan;
  logic        highEnough;
  logic        tailEnough;

  assign shiftIn    = {shift_ff[14:0], mdSync};
  assign codeTwo    =
    code_is(shiftIn, ddps_pkg::CODE_TO_TWO);
  assign codeScan   =
    code_is(shiftIn, ddps_pkg::CODE_TO_SCAN);
  assign highEnough = frame_met(highCnt_ff, HIGH_NEED);
  assign tailEnough = frame_met(highCnt_ff, TAIL_NEED);

  always_comb begin
    nxt_state   = state_ff;
    nxt_highCnt = highCnt_ff;
    nxt_shift   = shift_ff;
    nxt_bitCnt  = bitCnt_ff;
    nxt_twoWire = twoWire_ff;
    nxt_pendTwo = pendTwo_ff;
    if (clkRise && !bscan_ff) begin
      if (mdSync) begin
        if (highCnt_ff != CNT_MAX) nxt_highCnt = highCnt_ff + 1'b1;
      end else begin
        nxt_highCnt = '0;
      end
      case (state_ff)
        ddps_pkg::DET_IDLE: begin
          if (mdSync) nxt_state = ddps_pkg::DET_LEAD;
        end
        ddps_pkg::DET_LEAD: begin
          // First low bit after the lead-in starts the code
          if (!mdSync) begin
            if (highEnough) begin
              nxt_state  = ddps_pkg::DET_CODE;
              nxt_shift  = shiftIn;
              nxt_bitCnt = 5'd1;
            end else begin
              nxt_state = ddps_pkg::DET_IDLE;
            end
          end
        end
        ddps_pkg::DET_CODE: begin
          nxt_shift  = shiftIn;
          nxt_bitCnt = bitCnt_ff + 1'b1;
          if (bitCnt_ff == CODE_LAST) begin
            // High code bits must not count toward the trailing frame
            nxt_highCnt = '0;
            if (codeTwo && !twoWire_ff) begin
              nxt_state   = ddps_pkg::DET_TAIL;
              nxt_pendTwo = 1'b1;
            end else if (codeScan && twoWire_ff) begin
              nxt_state   = ddps_pkg::DET_TAIL;
              nxt_pendTwo = 1'b0;
            end else begin
              nxt_state = ddps_pkg::DET_IDLE;
            end
          end
        end
        ddps_pkg::DET_TAIL: begin
          // Switch only once the trailing frame is long enough
          if (!mdSync) begin
            nxt_state = ddps_pkg::DET_IDLE;
          end else if (tailEnough) begin
            nxt_state   = ddps_pkg::DET_LEAD;
            nxt_twoWire = pendTwo_ff;
          end
        end
        default: nxt_state = ddps_pkg::DET_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff   <= ddps_pkg::DET_IDLE;
      highCnt_ff <= '0;
      shift_ff   <= '0;
      bitCnt_ff  <= '0;
      twoWire_ff <= 1'b0;
      pendTwo_ff <= 1'b0;
    end else begin
      state_ff   <= nxt_state;
      highCnt_ff <= nxt_highCnt;
      shift_ff   <= nxt_shift;
      bitCnt_ff  <= nxt_bitCnt;
      twoWire_ff <= nxt_twoWire;
      pendTwo_ff <= nxt_pendTwo;
    end
  end

  wire dpAllowed = strapDone_ff & ~bscan_ff;
  assign scanPortEnable    = dpAllowed & ~twoWire_ff;
  assign twoWirePortEnable = dpAllowed & twoWire_ff;

  ////////////////////////////////////////////////////////////////////
  // Shared data-out / trace pin

  wire traceBit = traceCoreSel ? asyncTraceOut[1]
                               : asyncTraceOut[0];

  logic pinOut_ff;
  logic pinOe_ff;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pinOut_ff <= 1'b0;
      pinOe_ff  <= 1'b0;
    end else if (twoWirePortEnable) begin
      pinOut_ff <= traceBit;
      pinOe_ff  <= 1'b1;
    end else begin
      pinOut_ff <= scanDataOut;
      pinOe_ff  <= scanPortEnable & scanDataOutEn;
    end
  end

  assign dataOutTracePinOut = pinOut_ff;
  assign dataOutTracePinOe  = pinOe_ff;

  ////////////////////////////////////////////////////////////////////
  // Star routing to per-core access ports; no core-state gating
  // so access works whether the core runs, halts or sits in reset

  logic [1:0] access_ff;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      access_ff <= 2'b00;
    end else begin
      access_ff[0] <= dpAllowed & dpAccessReq & ~dpCoreSel;
      access_ff[1] <= dpAllowed & dpAccessReq & dpCoreSel;
    end
  end
  assign busAccessReq = access_ff;

  ////////////////////////////////////////////////////////////////////
  // Cross trigger, enables from the software config register

  ddps_cross_trigger uCt (
    .ref_clk     (ref_clk),
    .rst_b       (rst_b),
    .coreHalted  (coreHalted),
    .haltRequest (haltRequest),
    .ctEnable    (ctEnableCfg),
    .ctHaltOut   (ctHaltOut)
  );

endmodule

// ---- sim/ddps_port_select_chk.sv ----
// Concurrent checks on the ports of the debug port select block
`timescale 1ns/1ns
module ddps_port_select_chk (
  input wire logic       ref_clk,
  input wire logic       rst_b,
  input wire logic       testModeOut,
  input wire logic       boundaryScanOut,
  input wire logic       scanDataOutEn,
  input wire logic       dataOutTracePinOut,
  input wire logic       dataOutTracePinOe,
  input wire logic       scanPortEnable,
  input wire logic       twoWirePortEnable,
  input wire logic [1:0] asyncTraceOut,
  input wire logic       traceCoreSel,
  input wire logic       dpAccessReq,
  input wire logic       dpCoreSel,
  input wire logic [1:0] busAccessReq,
  input wire logic [1:0] coreHalted,
  input wire logic [1:0] haltRequest,
  input wire logic [1:0] ctEnableCfg,
  input wire logic [1:0] ctHaltOut
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);
  sequence core0Enters;
    ctEnableCfg[0] && $rose(coreHalted[0]);
  endsequence
  // Release only counts when no run-time request still holds the halt
  sequence core0Leaves;
    ctHaltOut[1] && $fell(coreHalted[0]) && !haltRequest[0];
  endsequence
  a_ports_excl: assert property (
    !(scanPortEnable && twoWirePortEnable))
    else $error("both debug protocols active");
  a_bscan_quiet: assert property (
    boundaryScanOut |-> !scanPortEnable && !twoWirePortEnable)
    else $error("debug port active in boundary scan");
  a_bscan_noreq: assert property (
    boundaryScanOut |=> busAccessReq == 2'h0)
    else $error("bus access in boundary scan");
  a_strap_hold: assert property (
    $past(boundaryScanOut) |-> boundaryScanOut)
    else $error("port kind strap changed before reset");
  a_test_hold: assert property (
    $past(testModeOut) |-> testModeOut)
    else $error("test strap changed before reset");
  a_trace_path: assert property (
    twoWirePortEnable && $past(twoWirePortEnable)
    |-> dataOutTracePinOe &&
    dataOutTracePinOut == $past(asyncTraceOut[traceCoreSel]))
    else $error("trace not on shared pin");
  a_scan_oe: assert property (
    scanPortEnable && $past(scanPortEnable)
    |-> dataOutTracePinOe == $past(scanDataOutEn))
    else $error("shared pin enable wrong in scan mode");
  a_access_req: assert property (
    dpAccessReq && scanPortEnable |=>
    busAccessReq == ($past(dpCoreSel) ? 2'h2 : 2'h1))
    else $error("bus access port request wrong");
  a_ct_enter: assert property (
    core0Enters |=> ctHaltOut[1])
    else $error("cross halt missing");
  a_ct_release: assert property (
    core0Leaves |=> !ctHaltOut[1])
    else $error("cross halt not released");
  a_ct_request: assert property (
    ctEnableCfg[1] && haltRequest[1] |=> ctHaltOut[0])
    else $error("requested cross halt missing");
  a_ct_off: assert property (
    !ctHaltOut[1] && !ctEnableCfg[0] |=> !ctHaltOut[1])
    else $error("cross halt while disabled");
endmodule
//////////////////////////////////////////
bind ddps_port_select ddps_port_select_chk u_chk (.ref_clk, .rst_b,
  .testModeOut, .boundaryScanOut, .scanDataOutEn, .dataOutTracePinOut,
  .dataOutTracePinOe, .scanPortEnable, .twoWirePortEnable, .asyncTraceOut,
  .traceCoreSel, .dpAccessReq, .dpCoreSel, .busAccessReq, .coreHalted,
  .haltRequest, .ctEnableCfg, .ctHaltOut);

// ---- sim/ddps_probe_model.sv ----
// Behavioural debug probe on the debug clock and mode/data line
`timescale 1ns/1ns
module ddps_probe_model (
  output logic debugClockLine,
  output logic modeDataLineIn
);
  initial begin
    debugClockLine = 1'h0;
    modeDataLineIn = 1'h0;
  end
  // One bit per 320 ns clock; the clock stands still between frames
  task automatic bit_out(input logic b);
    modeDataLineIn = b;
    #160 debugClockLine = 1'h1;
    #160 debugClockLine = 1'h0;
  endtask
  task automatic send(input int lead, input logic [15:0] code,
                      input int tail);
    for (int i = 0; i < lead; i++) bit_out(1'h1);
    for (int i = 15; i >= 0; i--) bit_out(code[i]);
    for (int i = 0; i < tail; i++) bit_out(1'h1);
    // Released line flips so a stale high is never mistaken for lead
    modeDataLineIn = 1'h0;
  endtask
endmodule

// ---- sim/ddps_port_select_tb_top.sv ----
// Self-checking bench for the debug port select block
`timescale 1ns/1ns
module ddps_port_select_tb_top;
  logic       ref_clk, rst_b, testSelectPin, portKindSelect;
  logic       testModeOut, boundaryScanOut, debugClockLine;
  logic       modeDataLineIn, scanDataOut, scanDataOutEn;
  logic       dataOutTracePinOut, dataOutTracePinOe, scanPortEnable;
  logic       twoWirePortEnable, traceCoreSel, dpAccessReq, dpCoreSel;
  logic [1:0] asyncTraceOut, busAccessReq, coreHalted, haltRequest;
  logic [1:0] ctEnableCfg, ctHaltOut, pin, mode;
  int         error_cnt = 0;
  int         n_checks = 0;
  assign pin = {dataOutTracePinOe, dataOutTracePinOut};
  assign mode = {scanPortEnable, twoWirePortEnable};
  ddps_port_select DUT (.ref_clk, .rst_b, .testSelectPin, .portKindSelect,
    .testModeOut, .boundaryScanOut, .debugClockLine, .modeDataLineIn,
    .scanDataOut, .scanDataOutEn, .dataOutTracePinOut, .dataOutTracePinOe,
    .scanPortEnable, .twoWirePortEnable, .asyncTraceOut, .traceCoreSel,
    .dpAccessReq, .dpCoreSel, .busAccessReq, .coreHalted, .haltRequest,
    .ctEnableCfg, .ctHaltOut);
  ddps_probe_model probe (.debugClockLine, .modeDataLineIn);
  initial begin
    ref_clk = 1'h0;
    forever #20 ref_clk = ~ref_clk;
  end
  //////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic chk(input logic [1:0] got, input logic [1:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Straps change only inside reset, so the latch sees them settled
  task automatic do_reset(input logic ts, input logic pk);
    tick(1);
    rst_b <= 1'h0;
    testSelectPin <= ts;
    portKindSelect <= pk;
    tick(16);
    rst_b <= 1'h1;
    tick(6);
  endtask
  task automatic access(input logic sel, input logic [1:0] exp);
    tick(1);
    dpCoreSel <= sel;
    dpAccessReq <= 1'h1;
    tick(1);
    dpAccessReq <= 1'h0;
    #1 chk(busAccessReq, exp);
  endtask
  task automatic frame(input logic [15:0] code, input int tail,
                       input logic [1:0] exp);
    probe.send(51, code, tail);
    tick(6);
    #1 chk(mode, exp);
  endtask
  task automatic t_straps();
    do_reset(1'h1, 1'h0);
    #1 chk({testModeOut, scanPortEnable}, 2'h3);
    do_reset(1'h0, 1'h0);
    #1 chk(mode, 2'h2);
    #1 chk({testModeOut, boundaryScanOut}, 2'h0);
  endtask
  task automatic t_pin();
    tick(1);
    scanDataOut <= 1'h1;
    scanDataOutEn <= 1'h1;
    tick(2);
    #1 chk(pin, 2'h3);
    tick(1);
    scanDataOutEn <= 1'h0;
    tick(2);
    #1 chk({1'h0, dataOutTracePinOe}, 2'h0);
  endtask
  task automatic t_link();
    frame(16'h79e6, 51, 2'h2);
    frame(ddps_pkg::CODE_TO_TWO, 51, 2'h1);
    tick(1);
    asyncTraceOut <= 2'h2;
    traceCoreSel <= 1'h1;
    tick(2);
    #1 chk(pin, 2'h3);
    tick(1);
    traceCoreSel <= 1'h0;
    tick(2);
    #1 chk(pin, 2'h2);
    frame(ddps_pkg::CODE_TO_TWO, 51, 2'h1);
    frame(ddps_pkg::CODE_TO_SCAN, 51, 2'h2);
    frame(ddps_pkg::CODE_TO_TWO, 50, 2'h2);
  endtask
  task automatic t_ct();
    tick(1);
    ctEnableCfg <= 2'h2;
    coreHalted <= 2'h1;
    tick(2);
    #1 chk(ctHaltOut, 2'h0);
    tick(1);
    coreHalted <= 2'h0;
    ctEnableCfg <= 2'h3;
    tick(1);
    coreHalted <= 2'h1;
    tick(2);
    #1 chk(ctHaltOut, 2'h2);
    access(1'h0, 2'h1);
    tick(1);
    coreHalted <= 2'h0;
    tick(2);
    #1 chk(ctHaltOut, 2'h0);
    tick(1);
    haltRequest <= 2'h2;
    tick(2);
    #1 chk(ctHaltOut, 2'h1);
    tick(1);
    haltRequest <= 2'h0;
  endtask
  // Strap moved without a reset must not change the latched choice
  task automatic t_bscan();
    do_reset(1'h0, 1'h1);
    #1 chk({boundaryScanOut, scanPortEnable}, 2'h2);
    access(1'h1, 2'h0);
    frame(ddps_pkg::CODE_TO_TWO, 51, 2'h0);
    tick(1);
    portKindSelect <= 1'h0;
    tick(4);
    #1 chk({boundaryScanOut, scanPortEnable}, 2'h2);
  endtask
  initial begin
    rst_b = 1'h0;
    {testSelectPin, portKindSelect, scanDataOut, scanDataOutEn} = 4'h0;
    {traceCoreSel, dpAccessReq, dpCoreSel} = 3'h0;
    {asyncTraceOut, coreHalted, haltRequest, ctEnableCfg} = 8'h00;
    t_straps();
    t_pin();
    access(1'h1, 2'h2);
    t_link();
    t_ct();
    t_bscan();
    stop_test();
  end
  initial begin
    #400000;
    error_cnt++;
    stop_test();
  end
endmodule
